// ---- common/tcp_defs.vh ----
// Purpose: Shared constants of the timer coprocessor core.
// Assumes: Included by every design file of the core.
// Notes: Microinstruction is 16 bits: opcode in the top three bits.
//
// Operation
// [R1] Two independent 16-bit free-running time bases
// [R2] Time base one: system clock through prescaler
// [R3] Time base two: system clock or pin
// [R4] Pin edges at least nine clocks apart
// [R5] Sixteen channels: capture, match, comparator, pin
// [R6] Enhanced channel 15 adds output disable
// [R7] Microengine, not host, sets pin direction
// [R8] Separate time base for match and capture
// [R9] Base: 100 words, six or eight each
// [R10] Enhanced: 128 words, eight per channel
// [R11] Parameter memory shared by host and engine
// [R12] Channels disabled until given a priority
// [R13] Service order by priority, then number
// [R14] Emulation RAM fetch, same speed as ROM
// [R15] Host blocked from emulation RAM in emulation
// [R16] Host sets function, level, priority first
// [R17] All channels identical and interchangeable; the code gives channel 15 alone an output disable when enhanced
// [R18] Time bases tick once per tick, wrap
`ifndef TCP_DEFS_VH
`define TCP_DEFS_VH

`define TCP_NCH          16
`define TCP_TBW          16
`define TCP_TB_ZERO      16'h0000
`define TCP_TB_ONE       16'h0001
`define TCP_PRE_W        8
`define TCP_PRE_ONES     8'hff
`define TCP_PRE_ZERO     8'h00
`define TCP_PRE_ONE      8'h01

`define TCP_UIW          16
`define TCP_UI_ZERO      16'h0000
`define TCP_OP_MSB       15
`define TCP_OP_LSB       13
`define TCP_OP_END       3'h0
`define TCP_OP_PIN       3'h1
`define TCP_OP_LDM       3'h2
`define TCP_OP_STC       3'h3
`define TCP_PIN_DIR      0
`define TCP_PIN_LVL      1
`define TCP_PIN_MSEL     2
`define TCP_PIN_CSEL     3
`define TCP_PIN_MEN      4
`define TCP_IDX_MSB      2
`define TCP_CS_AW        7
`define TCP_CS_DEPTH     128

`define TCP_PRAM_AW      7
`define TCP_PRAM_DEPTH   128
`define TCP_ENH_WORDS    8'h80
`define TCP_BASE_WORDS   8'h64
`define TCP_BASE_SHORT   4'he
`define TCP_SHORT_N      3'h6
`define TCP_SHORT_MUL    7'h06
`define TCP_LONG_BASE    7'h54
`define TCP_LONG_SHIFT   3
`define TCP_WORD_ZERO    16'h0000

`define TCP_PRI_OFF      2'h0
`define TCP_PRI_W        2
`define TCP_FSEL_W       4
`define TCP_CH_ZERO      4'h0

`define TCP_ST_IDLE      3'b001
`define TCP_ST_FETCH     3'b010
`define TCP_ST_EXEC      3'b100

`endif

// ---- hdl/tcp_channel.v ----
// Purpose: One timer channel: pin control and event register.
// Assumes: Pin input is synchronous to clock_i.
// Notes: Comparator is greater-or-equal across counter wrap.
`timescale 1ns/1ns
`include "tcp_defs.vh"
module tcp_channel #(
    parameter OUT_DIS_EN = 0
) (
    input  wire                 clock_i,
    input  wire                 rst_n_i,
    input  wire [`TCP_TBW-1:0]  tb1_i,
    input  wire [`TCP_TBW-1:0]  tb2_i,
    input  wire                 cfg_we_i,
    input  wire                 cfg_dir_i,
    input  wire                 cfg_lvl_i,
    input  wire                 cfg_msel_i,
    input  wire                 cfg_csel_i,
    input  wire                 cfg_men_i,
    input  wire                 match_we_i,
    input  wire [`TCP_TBW-1:0]  match_d_i,
    input  wire                 out_dis_i,
    input  wire                 pin_i,
    output reg                  pin_o,
    output reg                  oe_o,
    output reg  [`TCP_TBW-1:0]  capture_o,
    output reg                  match_ev_o,
    output reg                  cap_ev_o
);
    reg                 dir;
    reg                 lvl;
    reg                 msel;
    reg                 csel;
    reg                 men;
    reg                 pin_prev;
    reg  [`TCP_TBW-1:0] match;
    wire [`TCP_TBW-1:0] tb_m = msel ? tb2_i : tb1_i;   // [R8]
    wire [`TCP_TBW-1:0] tb_c = csel ? tb2_i : tb1_i;   // [R8]
    wire [`TCP_TBW-1:0] diff = tb_m - match;
    wire                ge   = ~diff[`TCP_TBW-1];      // [R5]
    wire                hit  = men & ge & ~match_we_i;
    wire                edge_seen = ~dir & (pin_i ^ pin_prev);
    wire                dis  = (OUT_DIS_EN != 0) & out_dis_i; // [R6]

    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dir        <= 1'b0;
            lvl        <= 1'b0;
            msel       <= 1'b0;
            csel       <= 1'b0;
            men        <= 1'b0;
            pin_prev   <= 1'b0;
            match      <= `TCP_TB_ZERO;
            pin_o      <= 1'b0;
            oe_o       <= 1'b0;
            capture_o  <= `TCP_TB_ZERO;
            match_ev_o <= 1'b0;
            cap_ev_o   <= 1'b0;
        end else begin
            pin_prev   <= pin_i;
            match_ev_o <= hit;
            cap_ev_o   <= edge_seen;
            oe_o       <= dir & ~dis;                  // [R6]
            if (cfg_we_i) begin
                dir  <= cfg_dir_i;                     // [R7]
                lvl  <= cfg_lvl_i;
                msel <= cfg_msel_i;
                csel <= cfg_csel_i;
                men  <= cfg_men_i;
            end else if (hit) begin
                men   <= 1'b0;
                pin_o <= lvl;                          // [R5]
            end
            if (match_we_i) begin
                match <= match_d_i;                    // [R5]
            end
            if (edge_seen) begin
                capture_o <= tb_c;                     // [R5]
            end
        end
    end
endmodule // tcp_channel

// ---- hdl/tcp_core.v ----
// Purpose: Timer coprocessor core: time bases, channels, scheduler,
//          microengine, parameter and emulation memories.
// Assumes: All inputs synchronous to clock_i; host ports are word wide.
// Notes: Priority code 0 disables a channel, 1 low, 2 middle, 3 high.
`timescale 1ns/1ns
`include "tcp_defs.vh"
module tcp_core #(
    parameter ENHANCED = 1
) (
    input  wire                          clock_i,
    input  wire                          rst_n_i,
    input  wire [2:0]                    pre1_sel_i,
    input  wire [2:0]                    pre2_sel_i,
    input  wire                          tb2_ext_sel_i,
    input  wire                          ext_time_base_clock_pin_i,
    input  wire [`TCP_NCH*`TCP_PRI_W-1:0] chan_prio_i,
    input  wire [`TCP_NCH*`TCP_FSEL_W-1:0] chan_func_i,
    input  wire [`TCP_NCH-1:0]           host_req_i,
    input  wire                          out_dis_i,
    input  wire [`TCP_NCH-1:0]           ch_pin_i,
    output wire [`TCP_NCH-1:0]           ch_pin_o,
    output wire [`TCP_NCH-1:0]           ch_oe_o,
    input  wire [`TCP_PRAM_AW-1:0]       pram_addr_i,
    input  wire                          pram_we_i,
    input  wire [`TCP_UIW-1:0]           pram_wdata_i,
    output reg  [`TCP_UIW-1:0]           pram_rdata_o,
    input  wire                          emu_mode_i,
    input  wire [`TCP_CS_AW-1:0]         emu_addr_i,
    input  wire                          emu_we_i,
    input  wire [`TCP_UIW-1:0]           emu_wdata_i,
    output reg  [`TCP_UIW-1:0]           emu_rdata_o,
    output reg  [`TCP_TBW-1:0]           tb1_o,
    output reg  [`TCP_TBW-1:0]           tb2_o,
    output reg                           svc_busy_o,
    output reg  [3:0]                    svc_ch_o
);
    reg  [`TCP_UIW-1:0]      pram    [0:`TCP_PRAM_DEPTH-1];
    reg  [`TCP_UIW-1:0]      emu_ram [0:`TCP_CS_DEPTH-1];
    reg  [`TCP_PRE_W-1:0]    pre1;
    reg  [`TCP_PRE_W-1:0]    pre2;
    reg                      ext_prev;
    reg  [`TCP_NCH-1:0]      pend;
    reg  [2:0]               state;
    reg  [`TCP_CS_AW-1:0]    pc;
    reg  [`TCP_UIW-1:0]      ir;
    reg  [3:0]               sel_ch;
    reg                      sel_any;
    reg  [`TCP_PRAM_AW-1:0]  eaddr;
    reg                      eaddr_ok;
    integer                  lv;
    integer                  c;
    wire [`TCP_NCH-1:0]      match_ev;
    wire [`TCP_NCH-1:0]      cap_ev;
    wire [`TCP_NCH*`TCP_TBW-1:0] cap_flat;
    wire [`TCP_NCH-1:0]      req;

    // Prescaled ticks: divide by two to the power of the select
    wire [`TCP_PRE_W-1:0] mask1 = ~(`TCP_PRE_ONES << pre1_sel_i);
    wire [`TCP_PRE_W-1:0] mask2 = ~(`TCP_PRE_ONES << pre2_sel_i);
    wire tick1   = (pre1 & mask1) == mask1;              // [R2]
    wire ext_rise = ext_time_base_clock_pin_i & ~ext_prev;
    // Pin edges are spaced by the source, so no edge is missed
    wire tick2   = tb2_ext_sel_i ? ext_rise :            // [R3] [R4]
                   ((pre2 & mask2) == mask2);

    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pre1     <= `TCP_PRE_ZERO;
            pre2     <= `TCP_PRE_ZERO;
            ext_prev <= 1'b0;
            tb1_o    <= `TCP_TB_ZERO;
            tb2_o    <= `TCP_TB_ZERO;
        end else begin
            pre1     <= pre1 + `TCP_PRE_ONE;
            pre2     <= pre2 + `TCP_PRE_ONE;
            ext_prev <= ext_time_base_clock_pin_i;
            if (tick1) begin
                tb1_o <= tb1_o + `TCP_TB_ONE;            // [R1] [R18]
            end
            if (tick2) begin
                tb2_o <= tb2_o + `TCP_TB_ONE;            // [R1] [R18]
            end
        end
    end

    // Microinstruction fields
    wire [2:0] op  = ir[`TCP_OP_MSB:`TCP_OP_LSB];
    wire [2:0] idx = ir[`TCP_IDX_MSB:0];
    wire st_idle  = state == `TCP_ST_IDLE;
    wire st_exec  = state == `TCP_ST_EXEC;
    wire do_pin   = st_exec & (op == `TCP_OP_PIN);
    wire do_ldm   = st_exec & (op == `TCP_OP_LDM) & eaddr_ok;
    wire do_stc   = st_exec & (op == `TCP_OP_STC) & eaddr_ok;
    wire [`TCP_TBW-1:0] cur_cap = cap_flat[svc_ch_o*`TCP_TBW +: `TCP_TBW];

    genvar g;
    generate
        for (g = 0; g < `TCP_NCH; g = g + 1) begin : g_ch
            tcp_channel #(
                .OUT_DIS_EN ((ENHANCED != 0) && (g == `TCP_NCH - 1))
            ) u_ch (                                     // [R5] [R17]
                .clock_i    (clock_i),
                .rst_n_i    (rst_n_i),
                .tb1_i      (tb1_o),
                .tb2_i      (tb2_o),
                .cfg_we_i   (do_pin & (svc_ch_o == g)),
                .cfg_dir_i  (ir[`TCP_PIN_DIR]),
                .cfg_lvl_i  (ir[`TCP_PIN_LVL]),
                .cfg_msel_i (ir[`TCP_PIN_MSEL]),
                .cfg_csel_i (ir[`TCP_PIN_CSEL]),
                .cfg_men_i  (ir[`TCP_PIN_MEN]),
                .match_we_i (do_ldm & (svc_ch_o == g)),
                .match_d_i  (pram[eaddr]),
                .out_dis_i  (out_dis_i),
                .pin_i      (ch_pin_i[g]),
                .pin_o      (ch_pin_o[g]),
                .oe_o       (ch_oe_o[g]),
                .capture_o  (cap_flat[g*`TCP_TBW +: `TCP_TBW]),
                .match_ev_o (match_ev[g]),
                .cap_ev_o   (cap_ev[g])
            );
            // Only a channel with a priority may ask for service
            assign req[g] = pend[g] &
                (chan_prio_i[g*`TCP_PRI_W +: `TCP_PRI_W] != `TCP_PRI_OFF);
            always @(posedge clock_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    pend[g] <= 1'b0;                     // [R12]
                end else if (host_req_i[g] | match_ev[g] | cap_ev[g]) begin
                    pend[g] <= 1'b1;
                end else if (st_idle & sel_any & (sel_ch == g)) begin
                    pend[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // Later assignment wins: highest level, then lowest number
    always @* begin
        sel_ch  = `TCP_CH_ZERO;
        sel_any = |req;
        for (lv = 1; lv < 4; lv = lv + 1) begin
            for (c = `TCP_NCH - 1; c >= 0; c = c - 1) begin
                if (req[c] && (chan_prio_i[c*`TCP_PRI_W +: `TCP_PRI_W]
                               == lv[1:0])) begin
                    sel_ch = c[3:0];                     // [R13]
                end
            end
        end
    end

    // Parameter word of the serviced channel
    always @* begin
        eaddr    = {`TCP_PRAM_AW{1'b0}};
        eaddr_ok = 1'b1;
        if (ENHANCED != 0) begin
            eaddr = {svc_ch_o, idx};                     // [R10]
        end else if (svc_ch_o < `TCP_BASE_SHORT) begin
            eaddr    = svc_ch_o * `TCP_SHORT_MUL + {4'h0, idx}; // [R9]
            eaddr_ok = idx < `TCP_SHORT_N;
        end else begin
            eaddr = `TCP_LONG_BASE +                     // [R9]
                ({6'h00, svc_ch_o[0]} << `TCP_LONG_SHIFT) + {4'h0, idx};
        end
    end

    // Control store ROM: one eight-word program per function
    function [`TCP_UIW-1:0] tcp_rom;
        input [`TCP_CS_AW-1:0] a;
        begin
            case (a[`TCP_IDX_MSB:0])
                3'h0:    tcp_rom = {`TCP_OP_STC, 13'h0000};
                3'h1:    tcp_rom = {`TCP_OP_LDM, 13'h0001};
                3'h2:    tcp_rom = {`TCP_OP_PIN, 8'h00, 1'b1, 1'b0,
                                    1'b0, a[3], a[3]};
                default: tcp_rom = {`TCP_OP_END, 13'h0000};
            endcase
        end
    endfunction

    wire pram_host_ok = {1'b0, pram_addr_i} <
        ((ENHANCED != 0) ? `TCP_ENH_WORDS : `TCP_BASE_WORDS);

    always @(posedge clock_i) begin
        if (do_stc) begin
            pram[eaddr] <= cur_cap;                      // [R11]
        end
        // Engine wins a same-word collision
        if (pram_we_i & pram_host_ok & ~(do_stc & (eaddr == pram_addr_i)))
        begin
            pram[pram_addr_i] <= pram_wdata_i;           // [R11]
        end
        if (emu_we_i & ~emu_mode_i) begin
            emu_ram[emu_addr_i] <= emu_wdata_i;          // [R15]
        end
    end

    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pram_rdata_o <= `TCP_WORD_ZERO;
            emu_rdata_o  <= `TCP_WORD_ZERO;
        end else begin
            pram_rdata_o <= pram_host_ok ? pram[pram_addr_i]
                                         : `TCP_WORD_ZERO;
            emu_rdata_o  <= emu_mode_i ? `TCP_WORD_ZERO  // [R15]
                                       : emu_ram[emu_addr_i];
        end
    end

    // Microengine: fetch takes one cycle from either store
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state      <= `TCP_ST_IDLE;
            pc         <= {`TCP_CS_AW{1'b0}};
            ir         <= `TCP_UI_ZERO;
            svc_busy_o <= 1'b0;
            svc_ch_o   <= `TCP_CH_ZERO;
        end else begin
            case (state)
                `TCP_ST_IDLE: begin
                    if (sel_any) begin
                        svc_ch_o   <= sel_ch;
                        svc_busy_o <= 1'b1;
                        // Entry point set by the host function choice
                        pc    <= {chan_func_i[sel_ch*`TCP_FSEL_W +:
                                              `TCP_FSEL_W], 3'h0}; // [R16]
                        state <= `TCP_ST_FETCH;
                    end
                end
                `TCP_ST_FETCH: begin
                    ir    <= emu_mode_i ? emu_ram[pc] : tcp_rom(pc); // [R14]
                    pc    <= pc + {{(`TCP_CS_AW-1){1'b0}}, 1'b1};
                    state <= `TCP_ST_EXEC;
                end
                `TCP_ST_EXEC: begin
                    if (op == `TCP_OP_END) begin
                        svc_busy_o <= 1'b0;
                        state      <= `TCP_ST_IDLE;
                    end else begin
                        state <= `TCP_ST_FETCH;
                    end
                end
                default: begin
                    state <= `TCP_ST_IDLE;
                end
            endcase
        end
    end
endmodule // tcp_core

// ---- testbench/tcp_core_properties.sv ----
// Purpose: Port properties of the timer coprocessor core.
// Assumes: One clock domain, reset asynchronous and active low.
// Notes: Host memory checks assume no engine write to the same word.
`timescale 1ns/1ns
module tcp_core_properties #(
    parameter ENHANCED = 1
) (
    input wire        clock_i,
    input wire        rst_n_i,
    input wire [2:0]  pre1_sel_i,
    input wire        tb2_ext_sel_i,
    input wire        ext_time_base_clock_pin_i,
    input wire [31:0] chan_prio_i,
    input wire        out_dis_i,
    input wire [15:0] ch_oe_o,
    input wire [6:0]  pram_addr_i,
    input wire        pram_we_i,
    input wire [15:0] pram_wdata_i,
    input wire [15:0] pram_rdata_o,
    input wire        emu_mode_i,
    input wire [15:0] emu_rdata_o,
    input wire [15:0] tb1_o,
    input wire [15:0] tb2_o,
    input wire        svc_busy_o,
    input wire [3:0]  svc_ch_o
);
    logic [2:0] up_cnt;
    logic [3:0] off_cnt;
    // Cycles since reset, cycles with every channel off
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            up_cnt  <= 3'h0;
            off_cnt <= 4'h0;
        end else begin
            if (up_cnt != 3'h7)
                up_cnt <= up_cnt + 3'h1;
            if (chan_prio_i != 32'h0)
                off_cnt <= 4'h0;
            else if (off_cnt != 4'hf)
                off_cnt <= off_cnt + 4'h1;
        end
    end
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);
    AST_TB1_STEP: assert property ($changed(tb1_o) |->
        tb1_o == $past(tb1_o) + 16'h0001)
        else $error("time base one skipped a value");
    AST_TB1_DIV: assert property (
        (up_cnt == 3'h7 && pre1_sel_i == 3'h2)[*8] |->
        tb1_o == $past(tb1_o, 4) + 16'h0001)
        else $error("time base one divide by four wrong");
    AST_TB2_TICK: assert property (
        up_cnt == 3'h7 && tb2_ext_sel_i &&
        $rose(ext_time_base_clock_pin_i) |-> ##[1:4] tb2_o != $past(tb2_o))
        else $error("external edge did not advance time base two");
    AST_PRAM_RDWR: assert property (
        pram_we_i && (ENHANCED != 0 || pram_addr_i < 7'h64) ##1
        !pram_we_i && $stable(pram_addr_i) |=>
        pram_rdata_o == $past(pram_wdata_i, 2))
        else $error("parameter word read back wrong");
    AST_EMU_BLOCK: assert property (emu_mode_i |=>
        emu_rdata_o == 16'h0000)
        else $error("emulation memory readable in emulation mode");
    AST_OFF_IDLE: assert property (off_cnt == 4'hf |-> !svc_busy_o)
        else $error("service while every channel is off");
    AST_SVC_PRIO: assert property ($rose(svc_busy_o) |->
        chan_prio_i[svc_ch_o*2 +: 2] != 2'h0)
        else $error("disabled channel serviced");
    AST_SVC_HOLD: assert property ($rose(svc_busy_o) |=>
        (svc_busy_o && $stable(svc_ch_o))[*6])
        else $error("service shorter than its program");
    AST_OE15_DIS: assert property (
        (out_dis_i && ENHANCED != 0)[*2] |-> !ch_oe_o[15])
        else $error("channel fifteen drives while disabled");
endmodule // tcp_core_properties

bind tcp_core tcp_core_properties #(.ENHANCED(ENHANCED)) u_props (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .pre1_sel_i(pre1_sel_i),
    .tb2_ext_sel_i(tb2_ext_sel_i),
    .ext_time_base_clock_pin_i(ext_time_base_clock_pin_i),
    .chan_prio_i(chan_prio_i), .out_dis_i(out_dis_i), .ch_oe_o(ch_oe_o),
    .pram_addr_i(pram_addr_i), .pram_we_i(pram_we_i),
    .pram_wdata_i(pram_wdata_i), .pram_rdata_o(pram_rdata_o),
    .emu_mode_i(emu_mode_i), .emu_rdata_o(emu_rdata_o),
    .tb1_o(tb1_o), .tb2_o(tb2_o), .svc_busy_o(svc_busy_o),
    .svc_ch_o(svc_ch_o)
);

// ---- testbench/tcp_ext_clk_model.sv ----
// Purpose: External source of the time base two clock pin.
// Assumes: Steps on falling edges of the system clock.
// Notes: Pin rests low between bursts.
`timescale 1ns/1ns
module tcp_ext_clk_model #(
    parameter GAP = 10
) (
    input  wire  clock_i,
    output logic pin_o
);
    initial pin_o = 1'b0;
    task pulses(input int n);
        for (int i = 0; i < n; i++) begin
            repeat (GAP / 2) @(negedge clock_i);
            pin_o = 1'b1;
            repeat (GAP - GAP / 2) @(negedge clock_i);
            pin_o = 1'b0;
        end
    endtask
endmodule // tcp_ext_clk_model

// ---- testbench/tcp_core_test.sv ----
// Purpose: Self-checking bench for the timer coprocessor core.
// Assumes: Enhanced variant; inputs change at falling edges.
// Notes: Match words stay parked far ahead until the emulation run.
`timescale 1ns/1ns
module tcp_core_test;
    logic        clock_i;
    logic        rst_n_i;
    logic [2:0]  pre1_sel_i;
    logic [2:0]  pre2_sel_i;
    logic        tb2_ext_sel_i;
    logic        ext_pin;
    logic [31:0] chan_prio_i;
    logic [63:0] chan_func_i;
    logic [15:0] host_req_i;
    logic        out_dis_i;
    logic [15:0] ch_pin_i;
    logic [15:0] ch_pin_o;
    logic [15:0] ch_oe_o;
    logic [6:0]  pram_addr_i;
    logic        pram_we_i;
    logic [15:0] pram_wdata_i;
    logic [15:0] pram_rdata_o;
    logic        emu_mode_i;
    logic [6:0]  emu_addr_i;
    logic        emu_we_i;
    logic [15:0] emu_wdata_i;
    logic [15:0] emu_rdata_o;
    logic [15:0] tb1_o;
    logic [15:0] tb2_o;
    logic        svc_busy_o;
    logic [3:0]  svc_ch_o;
    int          errors;
    int          check_count;
    int          cycles;
    tcp_ext_clk_model u_ext (.clock_i(clock_i), .pin_o(ext_pin));
    tcp_core #(.ENHANCED(1)) u_dut (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .pre1_sel_i(pre1_sel_i),
        .pre2_sel_i(pre2_sel_i), .tb2_ext_sel_i(tb2_ext_sel_i),
        .ext_time_base_clock_pin_i(ext_pin), .chan_prio_i(chan_prio_i),
        .chan_func_i(chan_func_i), .host_req_i(host_req_i),
        .out_dis_i(out_dis_i), .ch_pin_i(ch_pin_i), .ch_pin_o(ch_pin_o),
        .ch_oe_o(ch_oe_o), .pram_addr_i(pram_addr_i),
        .pram_we_i(pram_we_i), .pram_wdata_i(pram_wdata_i),
        .pram_rdata_o(pram_rdata_o), .emu_mode_i(emu_mode_i),
        .emu_addr_i(emu_addr_i), .emu_we_i(emu_we_i),
        .emu_wdata_i(emu_wdata_i), .emu_rdata_o(emu_rdata_o),
        .tb1_o(tb1_o), .tb2_o(tb2_o), .svc_busy_o(svc_busy_o),
        .svc_ch_o(svc_ch_o)
    );
    initial begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 4000) begin
            errors++;
            final_report;
        end
    end
    task final_report;
        if (errors == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task check(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task clk(input int n);
        repeat (n) @(negedge clock_i);
    endtask
    task tick_sync(input bit two);
        logic [15:0] t0;
        int n;
        begin
            t0 = two ? tb2_o : tb1_o;
            n = 0;
            while ((two ? tb2_o : tb1_o) === t0 && n < 20) begin
                clk(1);
                n++;
            end
            check(16'(n < 20), 16'h0001);
        end
    endtask
    task pram_wr(input logic [6:0] a, input logic [15:0] d);
        pram_addr_i = a;
        pram_wdata_i = d;
        pram_we_i = 1'b1;
        clk(1);
    endtask
    task pram_rd(input logic [6:0] a, input logic [15:0] e);
        pram_we_i = 1'b0;
        pram_addr_i = a;
        clk(1);
        check(pram_rdata_o, e);
    endtask
    task svc_seen(input logic [3:0] ch);
        int n;
        begin
            n = 0;
            while (svc_busy_o !== 1'b1 && n < 40) begin
                clk(1);
                n++;
            end
            check(16'(svc_busy_o), 16'h0001);
            check(16'(svc_ch_o), 16'(ch));
            n = 0;
            while (svc_busy_o === 1'b1 && svc_ch_o === ch && n < 40) begin
                clk(1);
                n++;
            end
            check(16'(n < 40), 16'h0001);
        end
    endtask
    task t_time;
        logic [15:0] t0;
        begin
            tick_sync(1'b0);
            t0 = tb1_o;
            clk(12);
            check(tb1_o, t0 + 16'h0003);
            tick_sync(1'b1);
            t0 = tb2_o;
            clk(8);
            check(tb2_o, t0 + 16'h0004);
            tb2_ext_sel_i = 1'b1;
            clk(4);
            t0 = tb2_o;
            u_ext.pulses(5);
            clk(6);
            check(tb2_o, t0 + 16'h0005);
        end
    endtask
    task t_mem;
        pram_wr(7'h7f, 16'h7e7e);
        pram_wr(7'h64, 16'h1234);
        pram_rd(7'h64, 16'h1234);
        pram_rd(7'h7f, 16'h7e7e);
        emu_addr_i = 7'h05;
        emu_wdata_i = 16'hc3c3;
        emu_we_i = 1'b1;
        clk(1);
        emu_mode_i = 1'b1;
        emu_wdata_i = 16'h0ff0;
        clk(1);
        emu_we_i = 1'b0;
        clk(1);
        check(emu_rdata_o, 16'h0000);
        emu_mode_i = 1'b0;
        clk(2);
        check(emu_rdata_o, 16'hc3c3);
    endtask
    task t_all;
        for (int c = 0; c < 16; c++)
            pram_wr(7'(c * 8 + 1), 16'h4000);
        pram_we_i = 1'b0;
        pre1_sel_i = 3'h7;
        chan_func_i = {16{4'h9}};
        clk(1);
        chan_prio_i = {16{2'h1}};
        clk(1);
        for (int c = 0; c < 16; c++) begin
            host_req_i = 16'h0001 << c;
            clk(1);
            host_req_i = 16'h0000;
            svc_seen(4'(c));
            clk(1);
            check(16'(ch_oe_o[c]), 16'h0001);
            check(16'(ch_pin_o[c]), 16'h0000);
        end
        out_dis_i = 1'b1;
        clk(2);
        check(16'(ch_oe_o[15]), 16'h0000);
        out_dis_i = 1'b0;
        clk(2);
        check(16'(ch_oe_o[15]), 16'h0001);
    endtask
    task t_order;
        chan_prio_i = 32'h0000_0c70;
        clk(1);
        host_req_i = 16'h00ac;
        clk(1);
        host_req_i = 16'h0000;
        svc_seen(4'h2);
        svc_seen(4'h5);
        svc_seen(4'h3);
        clk(20);
        check(16'(svc_busy_o), 16'h0000);
        chan_prio_i = 32'h0000_8c70;
        svc_seen(4'h7);
        chan_func_i[19:16] = 4'h0;
        chan_prio_i = 32'h0000_0300;
        clk(1);
        host_req_i = 16'h0010;
        clk(1);
        host_req_i = 16'h0000;
        svc_seen(4'h4);
        clk(1);
        check(16'(ch_oe_o[4]), 16'h0000);
        ch_pin_i = 16'h0010;
        svc_seen(4'h4);
    endtask
    // Four-word program from emulation RAM: load, drive, drive, end
    task t_emu;
        logic [63:0] prog;
        begin
            prog = 64'h0000_2003_2013_4002;
            pram_wr(7'h22, 16'h0000);
            pram_we_i = 1'b0;
            for (int i = 0; i < 4; i++) begin
                emu_addr_i = 7'(i);
                emu_wdata_i = prog[i*16 +: 16];
                emu_we_i = 1'b1;
                clk(1);
            end
            emu_we_i = 1'b0;
            emu_mode_i = 1'b1;
            host_req_i = 16'h0010;
            clk(1);
            host_req_i = 16'h0000;
            clk(1);
            check(16'(svc_busy_o), 16'h0001);
            clk(7);
            check(16'(svc_busy_o), 16'h0001);
            clk(1);
            chan_prio_i = 32'h0;
            check(16'(svc_busy_o), 16'h0000);
            check(16'(ch_oe_o[4]), 16'h0001);
            check(16'(ch_pin_o[4]), 16'h0001);
            emu_mode_i = 1'b0;
            clk(16);
            check(16'(svc_busy_o), 16'h0000);
        end
    endtask
    initial begin
        errors = 0;
        check_count = 0;
        cycles = 0;
        rst_n_i = 1'b0;
        pre1_sel_i = 3'h2;
        pre2_sel_i = 3'h1;
        tb2_ext_sel_i = 1'b0;
        chan_prio_i = 32'h0;
        chan_func_i = 64'h0;
        host_req_i = 16'h0;
        out_dis_i = 1'b0;
        ch_pin_i = 16'h0;
        pram_addr_i = 7'h0;
        pram_we_i = 1'b0;
        pram_wdata_i = 16'h0;
        emu_mode_i = 1'b0;
        emu_addr_i = 7'h0;
        emu_we_i = 1'b0;
        emu_wdata_i = 16'h0;
        clk(5);
        check(tb1_o, 16'h0000);
        check(ch_oe_o, 16'h0000);
        clk(1);
        rst_n_i = 1'b1;
        t_time;
        t_mem;
        t_all;
        t_order;
        t_emu;
        final_report;
    end
endmodule // tcp_core_test
